// ==== hw/debug_port_params.svh ====
// constants of the two-wire debug port target-select block
`ifndef DEBUG_PORT_PARAMS_SVH
`define DEBUG_PORT_PARAMS_SVH

`define TSEL_RESET      8'h00
`define SEL_PART_ID     8'h00
`define SEL_REVISION    8'h01
`define SEL_HALT        8'h02
`define SEL_PROG_EN     8'hDF
`define SEL_PROG_DATA   8'hBF
`define SEL_PROG_STAT   8'hB7
`define SEL_ADDR_HI     8'hAF
`define SEL_ADDR_LO     8'hAE
`define SEL_CKSUM0      8'hA9
`define SEL_CKSUM1      8'hAA
`define SEL_CKSUM2      8'hAB
`define SEL_CKSUM3      8'hAC

`define BUSY_BIT        7
`define STATUS_PAD      7'h00
`define HALT_RESET      8'h00
`define HALT_BIT        0
`define BYTE_ZERO       8'h00
`define PART_ID_DEFAULT 8'h5A
`define REVISION_DEFAULT 8'h00

`define CMD_WRITE_BIT   0
`define CNT_ZERO        3'h0
`define CNT_ONE         3'h1
`define LAST_INSTR_BIT  3'h1
`define LAST_DATA_BIT   3'h7
`define SYNC_ZERO       3'h0

`endif

// ==== hw/debug_port_pkg.sv ====
// types shared by the debug port modules
package debug_port_pkg;
  typedef enum logic [1:0] {
    CMD_DATA_RD = 2'h0,
    CMD_DATA_WR = 2'h1,
    CMD_ADDR_RD = 2'h2,
    CMD_ADDR_WR = 2'h3
  } cmd_type;

  typedef enum logic [2:0] {
    L_IDLE   = 3'h0,
    L_INSTR  = 3'h1,
    L_WDATA  = 3'h2,
    L_WAIT   = 3'h3,
    L_RDATA  = 3'h4,
    L_FINISH = 3'h5
  } link_state_type;

  typedef enum logic {
    SYS_IDLE  = 1'h0,
    SYS_FETCH = 1'h1
  } sys_state_type;
endpackage : debug_port_pkg

// ==== hw/link_xfer_if.sv ====
// handshake bundle between the link engine and the system side
`timescale 1ns/10ps
interface link_xfer_if;
  logic                    req_toggle;
  debug_port_pkg::cmd_type req_cmd;
  logic [7:0]              req_data;
  logic                    ack_toggle;
  logic [7:0]              rsp_data;

  modport link (output req_toggle, output req_cmd, output req_data, input ack_toggle, input rsp_data);
  modport core (input req_toggle, input req_cmd, input req_data, output ack_toggle, output rsp_data);
endinterface : link_xfer_if

// ==== hw/debug_link_engine.sv ====
// frame engine on the adapter's debug clock
`timescale 1ns/10ps
`include "debug_port_params.svh"
module debug_link_engine (
  input  wire logic  debug_clock_pin_i,
  input  wire logic  resetn_i,
  input  wire logic  data_in_i,
  output logic       data_out_o,
  output logic       data_oe_o,
  link_xfer_if.link  bus
);
  debug_port_pkg::link_state_type state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [1:0] cmd_reg, cmd_next;
  logic       req_reg, req_next;
  logic       out_reg, out_next;
  logic       oe_reg, oe_next;
  logic [2:0] ack_sync_reg, ack_sync_next;
  logic       ack_acc_reg, ack_acc_next;
  logic       ack_event;

  assign bus.req_toggle = req_reg;
  assign bus.req_cmd    = debug_port_pkg::cmd_type'(cmd_reg);
  assign bus.req_data   = shift_reg;
  assign data_out_o     = out_reg;
  assign data_oe_o      = oe_reg;

  // first sync stage feeds only the second
  assign ack_event = (ack_sync_reg[1] == ack_sync_reg[2]) && (ack_sync_reg[1] != ack_acc_reg);

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    cmd_next      = cmd_reg;
    req_next      = req_reg;
    out_next      = out_reg;
    oe_next       = oe_reg;
    ack_sync_next = {ack_sync_reg[1:0], bus.ack_toggle};
    ack_acc_next  = (ack_sync_reg[1] == ack_sync_reg[2]) ? ack_sync_reg[1] : ack_acc_reg;
    unique case (state_reg)
      debug_port_pkg::L_IDLE: begin
        if (!data_in_i) begin
          state_next = debug_port_pkg::L_INSTR;
          cnt_next   = `CNT_ZERO;
        end
      end
      debug_port_pkg::L_INSTR: begin
        cmd_next = {data_in_i, cmd_reg[1]};
        cnt_next = cnt_reg + `CNT_ONE;
        if (cnt_reg == `LAST_INSTR_BIT) begin
          cnt_next = `CNT_ZERO;
          if (cmd_next[`CMD_WRITE_BIT]) begin
            state_next = debug_port_pkg::L_WDATA;
          end else begin
            req_next   = ~req_reg;
            state_next = debug_port_pkg::L_WAIT;
            oe_next    = 1'b1;
            out_next   = 1'b0;
          end
        end
      end
      debug_port_pkg::L_WDATA: begin
        shift_next = {data_in_i, shift_reg[7:1]};
        cnt_next   = cnt_reg + `CNT_ONE;
        if (cnt_reg == `LAST_DATA_BIT) begin
          req_next   = ~req_reg;
          state_next = debug_port_pkg::L_WAIT;
          oe_next    = 1'b1;
          out_next   = 1'b0;
        end
      end
      debug_port_pkg::L_WAIT: begin
        // adapter must keep clocking here, the answer arrives only on its edges
        if (ack_event) begin
          out_next = 1'b1;
          if (cmd_reg[`CMD_WRITE_BIT]) begin
            state_next = debug_port_pkg::L_FINISH;
          end else begin
            shift_next = bus.rsp_data;
            cnt_next   = `CNT_ZERO;
            state_next = debug_port_pkg::L_RDATA;
          end
        end
      end
      debug_port_pkg::L_RDATA: begin
        out_next   = shift_reg[0];
        shift_next = {1'b0, shift_reg[7:1]};
        cnt_next   = cnt_reg + `CNT_ONE;
        if (cnt_reg == `LAST_DATA_BIT) begin
          state_next = debug_port_pkg::L_FINISH;
        end
      end
      debug_port_pkg::L_FINISH: begin
        oe_next    = 1'b0;
        out_next   = 1'b0;
        state_next = debug_port_pkg::L_IDLE;
      end
      default: begin
        oe_next    = 1'b0;
        state_next = debug_port_pkg::L_IDLE;
      end
    endcase
  end

  always_ff @(posedge debug_clock_pin_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg    <= debug_port_pkg::L_IDLE;
      cnt_reg      <= `CNT_ZERO;
      shift_reg    <= `BYTE_ZERO;
      cmd_reg      <= 2'h0;
      req_reg      <= 1'b0;
      out_reg      <= 1'b0;
      oe_reg       <= 1'b0;
      ack_sync_reg <= `SYNC_ZERO;
      ack_acc_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      cmd_reg      <= cmd_next;
      req_reg      <= req_next;
      out_reg      <= out_next;
      oe_reg       <= oe_next;
      ack_sync_reg <= ack_sync_next;
      ack_acc_reg  <= ack_acc_next;
    end
  end

  property p_pin_released;
    @(posedge debug_clock_pin_i) disable iff (!resetn_i)
      (state_reg == debug_port_pkg::L_IDLE || state_reg == debug_port_pkg::L_INSTR ||
       state_reg == debug_port_pkg::L_WDATA) |-> !oe_reg;
  endproperty
  a_pin_released: assert property (p_pin_released) else $error("data pin driven outside reply");

  property p_ready_bit;
    @(posedge debug_clock_pin_i) disable iff (!resetn_i)
      (state_reg == debug_port_pkg::L_WAIT && ack_event) |=> (oe_reg && out_reg);
  endproperty
  a_ready_bit: assert property (p_ready_bit) else $error("ready bit not driven after answer");
endmodule : debug_link_engine

// ==== hw/debug_port_target_select.sv ====
// system-side target select, status and routing of the two-wire debug port
// Function
// - an address write sets the 8-bit target select, which steers every later data command until the next one.
// - target 0x00 reads the fixed part identifier and ignores writes.
// - target 0x01 reads the fixed revision code and ignores writes.
// - target 0x02 reaches the halt control register.
// - targets 0xDF, 0xBF and 0xB7 reach program enable, program data and program status.
// - targets 0xAF and 0xAE reach the high and low program address bytes.
// - targets 0xA9 to 0xAC reach checksum bytes zero to three.
// - an address read returns status with bit 7 set while a memory operation is busy.
// - the port uses one shared data pin and one adapter-driven clock pin.
// - halt control bit 0 stops the processor and must be set before program enable, program data or address byte access.
`timescale 1ns/10ps
`include "debug_port_params.svh"
module debug_port_target_select #(
  parameter logic [7:0] PART_ID  = `PART_ID_DEFAULT, // arbitrary value
  parameter logic [7:0] REVISION = `REVISION_DEFAULT // arbitrary value
) (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic       debug_clock_pin_i,
  input  wire logic       debug_data_pin_i,
  output logic            debug_data_pin_o,
  output logic            debug_data_pin_oe_o,
  input  wire logic       prog_busy_i,
  input  wire logic [7:0] rd_data_i,
  output logic            data_wr_strobe_o,
  output logic            data_rd_strobe_o,
  output logic [7:0]      target_sel_o,
  output logic [7:0]      wr_data_o,
  output logic [7:0]      halt_control_o,
  output logic            cpu_halt_o
);
  link_xfer_if xfer ();

  debug_link_engine link_engine (
    .debug_clock_pin_i (debug_clock_pin_i),
    .resetn_i          (resetn_i),
    .data_in_i         (debug_data_pin_i),
    .data_out_o        (debug_data_pin_o),
    .data_oe_o         (debug_data_pin_oe_o),
    .bus               (xfer.link)
  );

  debug_port_pkg::sys_state_type state_reg, state_next;
  logic [7:0] tsel_reg, tsel_next;
  logic [7:0] halt_reg, halt_next;
  logic [7:0] rsp_reg, rsp_next;
  logic       ack_reg, ack_next;
  logic [2:0] req_sync_reg, req_sync_next;
  logic       req_acc_reg, req_acc_next;
  logic       wr_strobe_reg, wr_strobe_next;
  logic       rd_strobe_reg, rd_strobe_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic       req_event;
  logic       halted;
  logic       forwarded;
  logic       gated;
  logic       allowed;

  assign xfer.ack_toggle  = ack_reg;
  assign xfer.rsp_data    = rsp_reg;
  assign target_sel_o     = tsel_reg;
  assign halt_control_o   = halt_reg;
  assign cpu_halt_o       = halt_reg[`HALT_BIT];
  assign data_wr_strobe_o = wr_strobe_reg;
  assign data_rd_strobe_o = rd_strobe_reg;
  assign wr_data_o        = wr_data_reg;

  // request bundle is held by the link until acknowledged, so only the toggle needs syncing
  assign req_event = (req_sync_reg[1] == req_sync_reg[2]) && (req_sync_reg[1] != req_acc_reg);
  assign halted    = halt_reg[`HALT_BIT];

  // registers served by the program memory logic outside
  always_comb begin
    forwarded = 1'b0;
    gated     = 1'b0;
    unique case (tsel_reg)
      `SEL_PROG_EN, `SEL_PROG_DATA: begin
        forwarded = 1'b1;
        gated     = 1'b1;
      end
      `SEL_ADDR_HI, `SEL_ADDR_LO: begin
        forwarded = 1'b1;
        gated     = 1'b1;
      end
      `SEL_PROG_STAT: begin
        forwarded = 1'b1;
      end
      `SEL_CKSUM0, `SEL_CKSUM1, `SEL_CKSUM2, `SEL_CKSUM3: begin
        forwarded = 1'b1;
      end
      default: begin
        forwarded = 1'b0;
      end
    endcase
  end

  // program enable, data and address byte access only while the core is halted
  assign allowed = forwarded && (!gated || halted);

  always_comb begin
    state_next     = state_reg;
    tsel_next      = tsel_reg;
    halt_next      = halt_reg;
    rsp_next       = rsp_reg;
    ack_next       = ack_reg;
    wr_strobe_next = 1'b0;
    rd_strobe_next = 1'b0;
    wr_data_next   = wr_data_reg;
    req_sync_next  = {req_sync_reg[1:0], xfer.req_toggle};
    req_acc_next   = (req_sync_reg[1] == req_sync_reg[2]) ? req_sync_reg[1] : req_acc_reg;
    unique case (state_reg)
      debug_port_pkg::SYS_IDLE: begin
        if (req_event) begin
          ack_next = ~ack_reg;
          unique case (xfer.req_cmd)
            debug_port_pkg::CMD_ADDR_WR: begin
              tsel_next = xfer.req_data;
            end
            debug_port_pkg::CMD_ADDR_RD: begin
              // busy sampled at the moment of the read
              rsp_next = {prog_busy_i, `STATUS_PAD};
            end
            debug_port_pkg::CMD_DATA_WR: begin
              if (tsel_reg == `SEL_HALT) begin
                halt_next = xfer.req_data;
              end else if (allowed) begin
                wr_strobe_next = 1'b1;
                wr_data_next   = xfer.req_data;
              end
            end
            debug_port_pkg::CMD_DATA_RD: begin
              if (tsel_reg == `SEL_PART_ID) begin
                rsp_next = PART_ID;
              end else if (tsel_reg == `SEL_REVISION) begin
                rsp_next = REVISION;
              end else if (tsel_reg == `SEL_HALT) begin
                rsp_next = halt_reg;
              end else if (allowed) begin
                rd_strobe_next = 1'b1;
                ack_next       = ack_reg;
                state_next     = debug_port_pkg::SYS_FETCH;
              end else begin
                rsp_next = `BYTE_ZERO;
              end
            end
          endcase
        end
      end
      debug_port_pkg::SYS_FETCH: begin
        // outside logic answers in the same cycle as the read strobe, rd_data_i is taken at the edge that ends it
        rsp_next   = rd_data_i;
        ack_next   = ~ack_reg;
        state_next = debug_port_pkg::SYS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg     <= debug_port_pkg::SYS_IDLE;
      tsel_reg      <= `TSEL_RESET;
      halt_reg      <= `HALT_RESET;
      rsp_reg       <= `BYTE_ZERO;
      ack_reg       <= 1'b0;
      req_sync_reg  <= `SYNC_ZERO;
      req_acc_reg   <= 1'b0;
      wr_strobe_reg <= 1'b0;
      rd_strobe_reg <= 1'b0;
      wr_data_reg   <= `BYTE_ZERO;
    end else begin
      state_reg     <= state_next;
      tsel_reg      <= tsel_next;
      halt_reg      <= halt_next;
      rsp_reg       <= rsp_next;
      ack_reg       <= ack_next;
      req_sync_reg  <= req_sync_next;
      req_acc_reg   <= req_acc_next;
      wr_strobe_reg <= wr_strobe_next;
      rd_strobe_reg <= rd_strobe_next;
      wr_data_reg   <= wr_data_next;
    end
  end

  sequence s_fetch_done;
    data_rd_strobe_o ##1 (rsp_reg == $past(rd_data_i) && ack_reg != $past(ack_reg));
  endsequence

  property p_sel_load;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && xfer.req_cmd == debug_port_pkg::CMD_ADDR_WR) |=> (target_sel_o == $past(xfer.req_data));
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("target select not loaded");

  property p_sel_hold;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      !(req_event && xfer.req_cmd == debug_port_pkg::CMD_ADDR_WR) |=> $stable(target_sel_o);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("target select changed without write");

  property p_part_id;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && tsel_reg == `SEL_PART_ID && xfer.req_cmd[`CMD_WRITE_BIT] == 1'b0 && !xfer.req_cmd[1])
      |=> (rsp_reg == PART_ID && !data_rd_strobe_o);
  endproperty
  a_part_id: assert property (p_part_id) else $error("part identifier read wrong");

  property p_revision;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && tsel_reg == `SEL_REVISION && xfer.req_cmd == debug_port_pkg::CMD_DATA_RD)
      |=> (rsp_reg == REVISION);
  endproperty
  a_revision: assert property (p_revision) else $error("revision code read wrong");

  property p_halt_write;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && tsel_reg == `SEL_HALT && xfer.req_cmd == debug_port_pkg::CMD_DATA_WR)
      |=> (halt_control_o == $past(xfer.req_data) && !data_wr_strobe_o);
  endproperty
  a_halt_write: assert property (p_halt_write) else $error("halt control not written");

  property p_prog_write;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && halted && xfer.req_cmd == debug_port_pkg::CMD_DATA_WR &&
       (tsel_reg == `SEL_PROG_DATA || tsel_reg == `SEL_PROG_EN))
      |=> (data_wr_strobe_o && wr_data_o == $past(xfer.req_data) && target_sel_o == $past(tsel_reg));
  endproperty
  a_prog_write: assert property (p_prog_write) else $error("program write not forwarded");

  property p_addr_write;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && halted && xfer.req_cmd == debug_port_pkg::CMD_DATA_WR &&
       (tsel_reg == `SEL_ADDR_HI || tsel_reg == `SEL_ADDR_LO)) |=> data_wr_strobe_o;
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("address byte write not forwarded");

  property p_cksum_read;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && xfer.req_cmd == debug_port_pkg::CMD_DATA_RD &&
       tsel_reg >= `SEL_CKSUM0 && tsel_reg <= `SEL_CKSUM3) |=> s_fetch_done;
  endproperty
  a_cksum_read: assert property (p_cksum_read) else $error("checksum read not fetched");

  property p_busy_status;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && xfer.req_cmd == debug_port_pkg::CMD_ADDR_RD)
      |=> (rsp_reg[`BUSY_BIT] == $past(prog_busy_i) && rsp_reg[6:0] == `STATUS_PAD);
  endproperty
  a_busy_status: assert property (p_busy_status) else $error("status read wrong");

  property p_gate_unhalted;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && !halted && (tsel_reg == `SEL_PROG_DATA || tsel_reg == `SEL_ADDR_LO))
      |=> (!data_wr_strobe_o && !data_rd_strobe_o);
  endproperty
  a_gate_unhalted: assert property (p_gate_unhalted) else $error("program access while running");

  property p_answer_time;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      req_event |-> ##[1:2] (ack_reg != $past(ack_reg));
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("request not answered in time");

  property p_fixed_ignored;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && xfer.req_cmd == debug_port_pkg::CMD_DATA_WR &&
       (tsel_reg == `SEL_PART_ID || tsel_reg == `SEL_REVISION))
      |=> (!data_wr_strobe_o && $stable(halt_control_o));
  endproperty
  a_fixed_ignored: assert property (p_fixed_ignored) else $error("fixed register took a write");

  property p_halt_read;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && tsel_reg == `SEL_HALT && xfer.req_cmd == debug_port_pkg::CMD_DATA_RD)
      |=> (rsp_reg == $past(halt_reg) && !data_rd_strobe_o);
  endproperty
  a_halt_read: assert property (p_halt_read) else $error("halt control read wrong");

  // status stays reachable while running, the adapter needs it to poll
  property p_status_write;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && tsel_reg == `SEL_PROG_STAT && xfer.req_cmd == debug_port_pkg::CMD_DATA_WR)
      |=> (data_wr_strobe_o && wr_data_o == $past(xfer.req_data));
  endproperty
  a_status_write: assert property (p_status_write) else $error("status register write not forwarded");

  property p_gate_high;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && !halted && (tsel_reg == `SEL_PROG_EN || tsel_reg == `SEL_ADDR_HI))
      |=> (!data_wr_strobe_o && !data_rd_strobe_o);
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("program access while running");

  property p_gated_read;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (req_event && !halted && tsel_reg == `SEL_PROG_DATA && xfer.req_cmd == debug_port_pkg::CMD_DATA_RD)
      |=> (rsp_reg == `BYTE_ZERO);
  endproperty
  a_gated_read: assert property (p_gated_read) else $error("gated read not zero");

  property p_wr_pulse;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      data_wr_strobe_o |=> !data_wr_strobe_o;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");

  property p_rd_pulse;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      data_rd_strobe_o |=> !data_rd_strobe_o;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe longer than one cycle");
endmodule : debug_port_target_select

// ==== test/debug_adapter_model.sv ====
// behavioural programming adapter on the far side of the two-wire link
`timescale 1ns/10ps
module debug_adapter_model #(
  parameter int HALF = 3
) (
  output logic      dclk_o,
  output logic      drv_o,
  output logic      oe_o,
  input  wire logic wire_i
);
  int stretch = 0; // extra low time, a slow adapter

  initial begin
    dclk_o = 1'b0; // clock stands still outside frames
    drv_o  = 1'b1;
    oe_o   = 1'b0;
  end

  // data changes only while the clock is low, away from the sampling edge
  task automatic tick();
    #(HALF + stretch) dclk_o = 1'b1;
    #HALF dclk_o = 1'b0;
  endtask : tick

  // one frame on the clock and data pins only
  task automatic frame(input logic [1:0] cmd, input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    int n;
    rd = 8'h00;
    ok = 1'b0;
    oe_o = 1'b1;
    drv_o = 1'b0;
    tick();
    for (int i = 0; i < 2; i++) begin
      drv_o = cmd[i];
      tick();
    end
    if (cmd[0]) begin
      for (int i = 0; i < 8; i++) begin
        drv_o = wd[i];
        tick();
      end
    end
    oe_o = 1'b0;
    drv_o = 1'b1;
    // keep clocking through the wait bits, bounded
    for (n = 0; n < 400 && !ok; n++) begin
      tick();
      ok = (wire_i === 1'b1);
    end
    if (ok && !cmd[0]) begin
      for (int i = 0; i < 8; i++) begin
        tick();
        rd[i] = wire_i;
      end
    end
    repeat (3) tick();
  endtask : frame
endmodule : debug_adapter_model

// ==== test/tb_debug_port_target_select.sv ====
// self-checking bench of the debug port target select block
`timescale 1ns/10ps
`include "debug_port_params.svh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module tb_debug_port_target_select;
  localparam logic [7:0] PART_VAL = 8'h3C; // arbitrary value
  localparam logic [7:0] REV_VAL  = 8'h07; // arbitrary value
  logic       clk_sys_i, resetn_i, dclk, adp_drv, adp_oe, dev_out, dev_oe, wire_lvl, prog_busy_i;
  logic       data_wr_strobe_o, data_rd_strobe_o, cpu_halt_o, link_ok;
  logic [7:0] rd_data_i, target_sel_o, wr_data_o, halt_control_o, rd_val, wr_sel, rd_sel;
  int         err_count = 0, checks = 0, wr_cnt = 0, rd_cnt = 0, cycles = 0;

  // pull-up on the shared wire; device drive wins the overlap cycle
  assign wire_lvl = dev_oe ? dev_out : (adp_oe ? adp_drv : 1'b1);

  debug_adapter_model adapter (.dclk_o(dclk), .drv_o(adp_drv), .oe_o(adp_oe), .wire_i(wire_lvl));

  debug_port_target_select #(.PART_ID(PART_VAL), .REVISION(REV_VAL)) uut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .debug_clock_pin_i(dclk), .debug_data_pin_i(wire_lvl),
    .debug_data_pin_o(dev_out), .debug_data_pin_oe_o(dev_oe), .prog_busy_i(prog_busy_i),
    .rd_data_i(rd_data_i), .data_wr_strobe_o(data_wr_strobe_o), .data_rd_strobe_o(data_rd_strobe_o),
    .target_sel_o(target_sel_o), .wr_data_o(wr_data_o), .halt_control_o(halt_control_o),
    .cpu_halt_o(cpu_halt_o));

  initial clk_sys_i = 1'b0;
  always #25 clk_sys_i = ~clk_sys_i;

  // strobe monitor and hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (data_wr_strobe_o === 1'b1) begin
      wr_cnt++;
      wr_sel = target_sel_o;
    end
    if (data_rd_strobe_o === 1'b1) begin
      rd_cnt++;
      rd_sel = target_sel_o;
    end
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic set_in(input logic busy, input logic [7:0] rdv);
    @(posedge clk_sys_i);
    #1 prog_busy_i = busy;
    rd_data_i = rdv;
  endtask : set_in

  task automatic link(input logic [1:0] cmd, input logic [7:0] wd);
    adapter.frame(cmd, wd, rd_val, link_ok);
    `CHK("ready bit", 1'b1, link_ok)
    `CHK("wire released", 1'b0, dev_oe)
    repeat (2) @(posedge clk_sys_i);
  endtask : link

  task automatic sel(input logic [7:0] a);
    link(debug_port_pkg::CMD_ADDR_WR, a);
  endtask : sel

  task automatic wr(input logic [7:0] d);
    link(debug_port_pkg::CMD_DATA_WR, d);
  endtask : wr

  task automatic rd();
    link(debug_port_pkg::CMD_DATA_RD, 8'h00);
  endtask : rd

  task automatic t_reset();
    `CHK("select at reset", `TSEL_RESET, target_sel_o)
    `CHK("halt at reset", `HALT_RESET, halt_control_o)
    `CHK("link idle", 1'b0, dev_oe)
  endtask : t_reset

  task automatic t_fixed();
    logic [7:0] exp;
    int n;
    for (int k = 0; k < 2; k++) begin
      exp = (k == 0) ? PART_VAL : REV_VAL;
      n = wr_cnt;
      sel((k == 0) ? `SEL_PART_ID : `SEL_REVISION);
      wr(~exp);
      rd();
      `CHK("fixed read", exp, rd_val)
      `CHK("fixed write strobes", n, wr_cnt)
    end
  endtask : t_fixed

  // program registers refused while running, status still forwarded
  task automatic t_gated();
    int n;
    int m;
    n = wr_cnt;
    m = rd_cnt;
    set_in(1'b0, 8'h99);
    sel(`SEL_PROG_DATA);
    wr(8'h66);
    rd();
    `CHK("gated read", 8'h00, rd_val)
    sel(`SEL_ADDR_HI);
    wr(8'h66);
    `CHK("gated write strobes", n, wr_cnt)
    `CHK("gated read strobes", m, rd_cnt)
    sel(`SEL_PROG_STAT);
    wr(8'h12);
    `CHK("status reg write", n + 1, wr_cnt)
  endtask : t_gated

  task automatic t_halt();
    sel(`SEL_HALT);
    wr(8'h01);
    `CHK("halt reg", 8'h01, halt_control_o)
    `CHK("core halted", 1'b1, cpu_halt_o)
    rd();
    `CHK("halt read", 8'h01, rd_val)
  endtask : t_halt

  task automatic t_forward();
    logic [7:0] tbl [9];
    int n;
    tbl = '{`SEL_PROG_EN, `SEL_PROG_DATA, `SEL_PROG_STAT, `SEL_ADDR_HI, `SEL_ADDR_LO,
            `SEL_CKSUM0, `SEL_CKSUM1, `SEL_CKSUM2, `SEL_CKSUM3};
    for (int k = 0; k < 9; k++) begin
      n = wr_cnt;
      set_in(1'b0, ~tbl[k]);
      sel(tbl[k]);
      wr(tbl[k] ^ 8'h5A);
      rd();
      `CHK("write strobes", n + 1, wr_cnt)
      `CHK("write target", tbl[k], wr_sel)
      `CHK("write data", tbl[k] ^ 8'h5A, wr_data_o)
      `CHK("read target", tbl[k], rd_sel)
      `CHK("read data", ~tbl[k], rd_val)
      `CHK("select held", tbl[k], target_sel_o)
    end
  endtask : t_forward

  task automatic t_status();
    int n;
    set_in(1'b1, 8'h00);
    adapter.stretch = 2;
    link(debug_port_pkg::CMD_ADDR_RD, 8'h00);
    `CHK("busy status", {1'b1, `STATUS_PAD}, rd_val)
    `CHK("select kept", `SEL_CKSUM3, target_sel_o)
    set_in(1'b0, 8'h00);
    n = 0;
    do begin
      link(debug_port_pkg::CMD_ADDR_RD, 8'h00);
      n++;
    end while (rd_val[7] !== 1'b0 && n < 8);
    `CHK("idle status", 8'h00, rd_val)
    adapter.stretch = 0;
  endtask : t_status

  // unmapped place: write dropped, read gives zero
  task automatic t_unmapped();
    int n;
    int m;
    n = wr_cnt;
    m = rd_cnt;
    sel(8'h33);
    wr(8'hFF);
    rd();
    `CHK("unmapped read", 8'h00, rd_val)
    `CHK("unmapped write", n, wr_cnt)
    `CHK("unmapped rd strobe", m, rd_cnt)
    `CHK("unmapped select", 8'h33, target_sel_o)
  endtask : t_unmapped

  initial begin
    resetn_i = 1'b1;
    prog_busy_i = 1'b0;
    rd_data_i = 8'h00;
    // a real falling edge, the link flops get no clock during reset
    #1 resetn_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_reset();
    t_fixed();
    t_gated();
    t_halt();
    t_forward();
    t_status();
    t_unmapped();
    test_done();
  end
endmodule : tb_debug_port_target_select
